// [hdl/pts_tx_host.v]
`timescale 1ns/1ps
`include "pts_regs.vh"

module pts_tx_host (
  // clock, reset, enable
  input wire sys_clk_in,
  input wire nrst_in,
  input wire clk_en_in,
  // user side stream
  input wire usr_valid_in,
  output wire usr_ready_out,
  input wire [`PTS_DATA_W-1:0] usr_data_in,
  input wire usr_first_in,
  input wire usr_last_in,
  input wire usr_upper_unused_in,
  input wire usr_nullify_in,
  input wire [1:0] usr_ptype_in,
  input wire [`PTS_CRED_W-1:0] usr_credits_in,
  // transaction layer status and credit limits
  input wire transmit_accept_ready_in,
  input wire tl_fifo_empty_in,
  input wire [`PTS_CRED_W-1:0] cred_limit_cpl_in,
  input wire [`PTS_CRED_W-1:0] cred_limit_np_in,
  input wire [`PTS_CRED_W-1:0] cred_limit_p_in,
  // transaction layer stream
  output wire transmit_beat_valid_out,
  output wire [`PTS_DATA_W-1:0] transmit_beat_data_out,
  output wire transmit_packet_first_out,
  output wire transmit_packet_last_out,
  output wire transmit_upper_qword_unused_out,
  output wire transmit_nullify_strobe_out,
  // host status
  output wire link_idle_out,
  output wire credit_stall_out
);

  localparam [3:0] ST_WAIT = 4'h1;
  localparam [3:0] ST_IDLE = 4'h2;
  localparam [3:0] ST_PKT = 4'h4;
  localparam [3:0] ST_GAP = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function [`PTS_CRED_W-1:0] pick_by_type;
    input [1:0] ptype;
    input [`PTS_CRED_W-1:0] p_val;
    input [`PTS_CRED_W-1:0] np_val;
    input [`PTS_CRED_W-1:0] cpl_val;
    begin
      case (ptype)
        `PTS_PTYPE_POSTED: pick_by_type = p_val;
        `PTS_PTYPE_NONPOSTED: pick_by_type = np_val;
        default: pick_by_type = cpl_val;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // two-entry buffer

  reg [`PTS_ENT_W-1:0] buf_mem [0:1];
  reg buf_wr_ptr_reg;
  reg buf_rd_ptr_reg;
  reg [1:0] buf_count_reg;
  reg [1:0] buf_count_next;
  reg usr_ready_reg;

  wire push = usr_valid_in & usr_ready_reg;
  wire buf_nonempty = (buf_count_reg != 2'h0);
  wire [`PTS_ENT_W-1:0] head = buf_mem[buf_rd_ptr_reg];
  wire head_first = head[`PTS_ENT_FIRST];
  wire head_last = head[`PTS_ENT_LAST];
  wire [1:0] head_ptype = head[`PTS_ENT_PTYPE_HI:`PTS_ENT_PTYPE_LO];
  wire [`PTS_CRED_W-1:0] head_cred = head[`PTS_ENT_CRED_HI:`PTS_ENT_CRED_LO];

  ////////////////////////////////////////////////////////////////////////////
  // state

  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [1:0] wait_cnt_reg;
  reg ready_q_reg;
  reg pkt_nullable_reg;
  reg null_done_reg;
  reg [`PTS_CRED_W-1:0] used_p_reg;
  reg [`PTS_CRED_W-1:0] used_np_reg;
  reg [`PTS_CRED_W-1:0] used_cpl_reg;

  reg out_valid_reg;
  reg [`PTS_DATA_W-1:0] out_data_reg;
  reg out_first_reg;
  reg out_last_reg;
  reg out_empty_reg;
  reg out_null_reg;
  reg link_idle_reg;
  reg credit_stall_reg;

  // running credit account: limits are cumulative, so space is limit minus used, modulo 12 bits
  wire [`PTS_CRED_W-1:0] sel_limit = pick_by_type(head_ptype, cred_limit_p_in, cred_limit_np_in, cred_limit_cpl_in);
  wire [`PTS_CRED_W-1:0] sel_used = pick_by_type(head_ptype, used_p_reg, used_np_reg, used_cpl_reg);
  wire [`PTS_CRED_W-1:0] cred_space = sel_limit - sel_used;
  wire cred_ok = (head_cred <= cred_space);

  wire start_ok = (state_reg == ST_IDLE) & head_first & cred_ok;
  // only the registered ready gates a beat, so valid lands two cycles after ready
  wire issue = ready_q_reg & buf_nonempty & (start_ok | (state_reg == ST_PKT));
  // a stray non-first beat outside a packet is discarded rather than hanging the buffer;
  // inside a packet nothing is dropped or added, so the beat count is exactly the user's framing
  wire drop = (state_reg == ST_IDLE) & buf_nonempty & ~head_first;
  wire pop = issue | drop;

  wire mid_beat = (state_reg == ST_PKT) & ~head_last;
  wire null_now = issue & mid_beat & pkt_nullable_reg & ~null_done_reg & head[`PTS_ENT_NULL];

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always @* begin
    buf_count_next = buf_count_reg;
    if (push & ~pop) begin
      buf_count_next = buf_count_reg + 2'h1;
    end else if (pop & ~push) begin
      buf_count_next = buf_count_reg - 2'h1;
    end
  end

  reg buf_wr_ptr_next;
  reg buf_rd_ptr_next;

  always @* begin
    buf_wr_ptr_next = buf_wr_ptr_reg;
    buf_rd_ptr_next = buf_rd_ptr_reg;
    if (push) begin
      buf_wr_ptr_next = ~buf_wr_ptr_reg;
    end
    if (pop) begin
      buf_rd_ptr_next = ~buf_rd_ptr_reg;
    end
  end

  reg [1:0] wait_cnt_next;

  always @* begin
    wait_cnt_next = wait_cnt_reg;
    if (state_reg == ST_WAIT) begin
      wait_cnt_next = wait_cnt_reg + 2'h1;
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_WAIT: begin
        if (wait_cnt_reg == `PTS_RESET_WAIT_CYC) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (issue & ~head_last) begin
          state_next = ST_PKT;
        end
      end
      ST_PKT: begin
        if (issue & head_last) begin
          state_next = (null_done_reg | null_now) ? ST_GAP : ST_IDLE;
        end
      end
      ST_GAP: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_WAIT;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // packet bookkeeping

  reg pkt_nullable_next;
  reg null_done_next;
  reg [`PTS_CRED_W-1:0] used_p_next;
  reg [`PTS_CRED_W-1:0] used_np_next;
  reg [`PTS_CRED_W-1:0] used_cpl_next;

  always @* begin
    pkt_nullable_next = pkt_nullable_reg;
    null_done_next = null_done_reg;
    used_p_next = used_p_reg;
    used_np_next = used_np_reg;
    used_cpl_next = used_cpl_reg;
    if (issue & (state_reg == ST_IDLE)) begin
      // posted or completion with payload only; a non-posted packet is never nullified
      pkt_nullable_next = (head_ptype != `PTS_PTYPE_NONPOSTED) & (head_cred != 12'h000);
      null_done_next = 1'b0;
      // charged once, at the first beat; a wrap is harmless since space is taken modulo 12 bits
      case (head_ptype)
        `PTS_PTYPE_POSTED: begin
          used_p_next = used_p_reg + head_cred;
        end
        `PTS_PTYPE_NONPOSTED: begin
          used_np_next = used_np_reg + head_cred;
        end
        default: begin
          used_cpl_next = used_cpl_reg + head_cred;
        end
      endcase
    end else if (null_now) begin
      null_done_next = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stream outputs

  reg out_valid_next;
  reg [`PTS_DATA_W-1:0] out_data_next;
  reg out_first_next;
  reg out_last_next;
  reg out_empty_next;
  reg out_null_next;
  reg link_idle_next;
  reg credit_stall_next;

  // limitation: a low clock enable holds valid, so the device would see a held beat twice
  always @* begin
    // valid follows the registered ready, so it drops two cycles after ready does
    out_valid_next = issue;
    out_data_next = out_data_reg;
    if (issue) begin
      out_data_next = head[`PTS_DATA_W-1:0];
    end
    out_first_next = issue & head_first & (state_reg == ST_IDLE);
    out_last_next = issue & head_last;
    // fixed 128-bit bus: the flag is driven, and only ever on a last beat
    out_empty_next = issue & head_last & head[`PTS_ENT_EMPTY];
    out_null_next = null_now;
    // the device's own fifo flag joins ours to say nothing is in flight
    link_idle_next = tl_fifo_empty_in & (state_reg == ST_IDLE) & ~buf_nonempty & ~out_valid_reg;
    credit_stall_next = (state_reg == ST_IDLE) & buf_nonempty & head_first & ~cred_ok;
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      buf_wr_ptr_reg <= 1'b0;
      buf_rd_ptr_reg <= 1'b0;
      buf_count_reg <= 2'h0;
      usr_ready_reg <= 1'b0;
      state_reg <= ST_WAIT;
      wait_cnt_reg <= 2'h0;
      ready_q_reg <= 1'b0;
      pkt_nullable_reg <= 1'b0;
      null_done_reg <= 1'b0;
      used_p_reg <= 12'h000;
      used_np_reg <= 12'h000;
      used_cpl_reg <= 12'h000;
      out_valid_reg <= 1'b0;
      out_data_reg <= 128'h0;
      out_first_reg <= 1'b0;
      out_last_reg <= 1'b0;
      out_empty_reg <= 1'b0;
      out_null_reg <= 1'b0;
      link_idle_reg <= 1'b0;
      credit_stall_reg <= 1'b0;
    end else if (clk_en_in) begin
      if (push) begin
        buf_mem[buf_wr_ptr_reg] <= {usr_credits_in, usr_ptype_in, usr_nullify_in,
                                    usr_upper_unused_in, usr_last_in, usr_first_in, usr_data_in};
      end
      buf_wr_ptr_reg <= buf_wr_ptr_next;
      buf_rd_ptr_reg <= buf_rd_ptr_next;
      buf_count_reg <= buf_count_next;
      // ready reflects the fill after this cycle, so a stall downstream never loses a word
      usr_ready_reg <= (buf_count_next != 2'h2);

      state_reg <= state_next;
      wait_cnt_reg <= wait_cnt_next;
      ready_q_reg <= transmit_accept_ready_in;

      pkt_nullable_reg <= pkt_nullable_next;
      null_done_reg <= null_done_next;
      used_p_reg <= used_p_next;
      used_np_reg <= used_np_next;
      used_cpl_reg <= used_cpl_next;

      out_valid_reg <= out_valid_next;
      out_data_reg <= out_data_next;
      out_first_reg <= out_first_next;
      out_last_reg <= out_last_next;
      out_empty_reg <= out_empty_next;
      out_null_reg <= out_null_next;
      link_idle_reg <= link_idle_next;
      credit_stall_reg <= credit_stall_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign usr_ready_out = usr_ready_reg;
  assign transmit_beat_valid_out = out_valid_reg;
  assign transmit_beat_data_out = out_data_reg;
  assign transmit_packet_first_out = out_first_reg;
  assign transmit_packet_last_out = out_last_reg;
  assign transmit_upper_qword_unused_out = out_empty_reg;
  assign transmit_nullify_strobe_out = out_null_reg;
  assign link_idle_out = link_idle_reg;
  assign credit_stall_out = credit_stall_reg;

endmodule // pts_tx_host

// [hdl/pts_regs.vh]
`ifndef PTS_REGS_VH
`define PTS_REGS_VH

`define PTS_DATA_W 128
`define PTS_CRED_W 12
`define PTS_CRED_BYTES 16
`define PTS_READY_LATENCY 2
`define PTS_RESET_WAIT_CYC 2'h2

`define PTS_PTYPE_POSTED 2'h0
`define PTS_PTYPE_NONPOSTED 2'h1
`define PTS_PTYPE_COMPLETION 2'h2

`define PTS_ENT_W 146
`define PTS_ENT_FIRST 128
`define PTS_ENT_LAST 129
`define PTS_ENT_EMPTY 130
`define PTS_ENT_NULL 131
`define PTS_ENT_PTYPE_LO 132
`define PTS_ENT_PTYPE_HI 133
`define PTS_ENT_CRED_LO 134
`define PTS_ENT_CRED_HI 145

`endif

// [tb/pts_tx_host_assertions.sv]
`timescale 1ns/1ps
module pts_tx_host_assertions (
  // clock and reset
  input wire sys_clk_in,
  input wire nrst_in,
  // device side
  input wire transmit_accept_ready_in,
  input wire transmit_beat_valid_out,
  input wire transmit_packet_first_out,
  input wire transmit_packet_last_out,
  input wire transmit_upper_qword_unused_out,
  input wire transmit_nullify_strobe_out,
  input wire credit_stall_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  reg nul_pkt_reg;
  always @(posedge sys_clk_in) begin
    if (!nrst_in || (transmit_beat_valid_out && transmit_packet_last_out)) nul_pkt_reg <= 1'b0;
    else if (transmit_nullify_strobe_out) nul_pkt_reg <= 1'b1;
  end
  valid_ready_lat_a: assert property (transmit_beat_valid_out |-> $past(transmit_accept_ready_in, 2))
    else $error("valid without ready two cycles before");
  valid_drop_a: assert property (!transmit_accept_ready_in |-> ##2 !transmit_beat_valid_out)
    else $error("valid kept after ready dropped");
  marker_valid_a: assert property ((transmit_packet_first_out || transmit_packet_last_out) |-> transmit_beat_valid_out)
    else $error("marker without valid");
  unused_last_a: assert property (transmit_upper_qword_unused_out |-> transmit_beat_valid_out && transmit_packet_last_out)
    else $error("empty flag off the last beat");
  null_pulse_a: assert property (transmit_nullify_strobe_out |=> !transmit_nullify_strobe_out)
    else $error("nullify longer than one cycle");
  null_middle_a: assert property (transmit_nullify_strobe_out |->
    transmit_beat_valid_out && !transmit_packet_first_out && !transmit_packet_last_out)
    else $error("nullify outside a middle beat");
  null_gap_a: assert property (transmit_beat_valid_out && transmit_packet_last_out && nul_pkt_reg
    |=> !transmit_beat_valid_out)
    else $error("no gap after nullified packet");
  reset_wait_a: assert property (disable iff (1'b0) $rose(nrst_in) |-> !transmit_beat_valid_out [*3])
    else $error("beat too soon after reset");
  cover property (transmit_nullify_strobe_out);
  cover property (transmit_upper_qword_unused_out);
  cover property (credit_stall_out);
endmodule // pts_tx_host_assertions
bind pts_tx_host pts_tx_host_assertions u_chk (.sys_clk_in, .nrst_in, .transmit_accept_ready_in,
  .transmit_beat_valid_out, .transmit_packet_first_out, .transmit_packet_last_out,
  .transmit_upper_qword_unused_out, .transmit_nullify_strobe_out, .credit_stall_out);

// [tb/pts_dev_model.sv]
`timescale 1ns/1ps
module pts_dev_model (
  // clock and reset
  input wire sys_clk_in,
  input wire nrst_in,
  // bench controls
  input wire rdy_en_in,
  input wire add_p_in,
  // stream from host
  input wire beat_valid_in,
  // status to host
  output reg ready_out,
  output reg fifo_empty_out,
  output reg [11:0] lim_cpl_out,
  output reg [11:0] lim_np_out,
  output reg [11:0] lim_p_out
);
  reg [2:0] cnt_reg;
  reg [1:0] idle_reg;
  always @(posedge sys_clk_in) begin
    if (!nrst_in) begin
      cnt_reg <= 3'h0;
      ready_out <= 1'b0;
      idle_reg <= 2'h0;
      fifo_empty_out <= 1'b1;
      lim_cpl_out <= 12'h100;
      lim_np_out <= 12'h100;
      lim_p_out <= 12'h010;
    end else begin
      cnt_reg <= cnt_reg + 3'h1;
      // periodic throttle so the host must drop and resume valid
      ready_out <= rdy_en_in && (cnt_reg != 3'h5);
      idle_reg <= beat_valid_in ? 2'h3 : idle_reg - {1'b0, idle_reg != 2'h0};
      fifo_empty_out <= (idle_reg == 2'h0) && !beat_valid_in;
      if (add_p_in) lim_p_out <= lim_p_out + 12'h040;
    end
  end
endmodule // pts_dev_model

// [tb/pts_tx_host_tb.sv]
`timescale 1ns/1ps
module pts_tx_host_tb;
  reg clk = 0, nrst = 0, u_valid = 0, u_first = 0, u_last = 0, u_un = 0, u_nul = 0, rdy_en = 1, add_p = 0;
  reg [127:0] u_data = 0;
  reg [1:0] u_pt = 0;
  reg [11:0] u_cr = 0;
  reg [31:0] rnd = 32'hA94D;
  wire usr_ready, ready, fempty, idle, stall, o_valid, o_first, o_last, o_un, o_nul;
  wire [11:0] lc, ln, lp;
  wire [127:0] o_data;
  reg [131:0] exp_q[$];
  integer n_fail = 0, n_compared = 0, k;
  initial forever #5 clk = ~clk;
  pts_dev_model u_dev (.sys_clk_in(clk), .nrst_in(nrst), .rdy_en_in(rdy_en), .add_p_in(add_p),
    .beat_valid_in(o_valid), .ready_out(ready), .fifo_empty_out(fempty), .lim_cpl_out(lc),
    .lim_np_out(ln), .lim_p_out(lp));
  pts_tx_host dut (.sys_clk_in(clk), .nrst_in(nrst), .clk_en_in(1'b1), .usr_valid_in(u_valid),
    .usr_ready_out(usr_ready), .usr_data_in(u_data), .usr_first_in(u_first), .usr_last_in(u_last),
    .usr_upper_unused_in(u_un), .usr_nullify_in(u_nul), .usr_ptype_in(u_pt), .usr_credits_in(u_cr),
    .transmit_accept_ready_in(ready), .tl_fifo_empty_in(fempty), .cred_limit_cpl_in(lc),
    .cred_limit_np_in(ln), .cred_limit_p_in(lp), .transmit_beat_valid_out(o_valid),
    .transmit_beat_data_out(o_data), .transmit_packet_first_out(o_first), .transmit_packet_last_out(o_last),
    .transmit_upper_qword_unused_out(o_un), .transmit_nullify_strobe_out(o_nul),
    .link_idle_out(idle), .credit_stall_out(stall));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task check(input [63:0] name, input [131:0] seen, input [131:0] exp);
    n_compared = n_compared + 1;
    if (seen !== exp) begin
      n_fail = n_fail + 1;
      $display("BAD %0s exp %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task send_pkt(input integer len, input [1:0] pt, input [11:0] cr, input nul, input un);
    integer b, i;
    for (b = 0; b < len; b = b + 1) begin
      u_valid = 1; u_data = {rnd, ~rnd, rnd, lfsr(rnd)}; u_first = (b == 0); u_last = (b == len - 1);
      u_un = un; u_nul = nul; u_pt = pt; u_cr = cr; rnd = lfsr(rnd);
      // nullify lands on beat one of long payload packets only
      exp_q.push_back({nul && b == 1 && len >= 3 && pt != 2'h1 && cr != 0, un && u_last, u_last, u_first, u_data});
      for (i = 0; i < 300 && usr_ready !== 1'b1; i = i + 1) begin @(posedge clk); #1; end
      if (i == 300) begin n_fail = n_fail + 1; finish_test; end
      @(posedge clk); #1;
    end
    // valid stays up so the next packet follows back to back; drain lowers it
  endtask
  task drain;
    integer i;
    u_valid = 0;
    for (i = 0; i < 500 && exp_q.size() != 0; i = i + 1) @(posedge clk);
    #1;
    if (exp_q.size() != 0) begin n_fail = n_fail + 1; finish_test; end
  endtask
  always @(posedge clk) begin
    if (nrst && o_valid) begin
      if (exp_q.size() == 0) check("extra", 1, 0);
      else check("beat", {o_nul, o_un, o_last, o_first, o_data}, exp_q.pop_front());
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 nrst = 1;
    repeat (2) @(posedge clk);
    #1;
    for (k = 0; k < 9; k = k + 1) begin
      send_pkt(1 + rnd % 5, k % 3, (k % 3 == 0) ? 12'h002 : k % 3, k % 2, rnd[3]);
      rnd = lfsr(rnd);
    end
    send_pkt(2, 0, 2, 1, 0);
    send_pkt(3, 2, 0, 1, 0);
    send_pkt(4, 0, 2, 1, 1);
    send_pkt(3, 2, 2, 0, 0);
    drain;
    repeat (10) @(posedge clk);
    #1 check("idle", idle, 1);
    rdy_en = 0;
    // stalled device: buffer must fill and refuse without losing words
    fork
      send_pkt(6, 2, 2, 0, 1);
      begin repeat (30) @(posedge clk); #1 check("full", usr_ready, 0); rdy_en = 1; end
    join
    drain;
    fork
      send_pkt(2, 0, 12'h00F, 0, 0);
      begin
        repeat (20) @(posedge clk);
        #1 check("stall", stall, 1);
        check("held", exp_q.size() == 2, 1);
        add_p = 1;
        @(posedge clk);
        #1 add_p = 0;
      end
    join
    drain;
    finish_test;
  end
endmodule // pts_tx_host_tb
